// *** mcr_regs.sv ***
// mac-side configuration and status register bank on avalon-mm
// Notes on behaviour
// - bypass enable defaults 1, applied at soft reset
// - bypass status shows link came up via bypass
// - bypass status set forces negotiation-complete low
// - transmitter disable bit, default 0, kept on soft reset
// - preamble option 0 pads, 1 passes, default 1
// - rx clock control default 1 keeps clock running
// - rx clock control applied only at soft reset
// - three interrupt enables, default 0, kept on soft reset
// - fifo over/underflow status latches high
// - idle inserted and deleted status latch high
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module mcr_regs
  import mcr_pkg::*;
(
  input wire logic clk_sys, // 250 mhz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] address, // byte address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [31:0] writedata, // write data, low 16 bits used
  output logic [31:0] readdata, // read data
  output logic waitrequest, // high until access completes
  input wire mcr_evt_t evt_i, // datapath events, same clock
  output mcr_cfg_t cfg_o, // applied settings
  output logic an_done_o, // fiber negotiation complete, gated
  output logic irq_o // level interrupt, active high
);

  // ****************************************************************
  // state
  // ****************************************************************
  mcr_state_t s_q; // registered state
  mcr_state_t s_d; // next state
  logic done; // access completes at this edge
  logic wr_acc; // write takes effect
  logic rd_acc; // read completes
  logic sw_rst; // soft reset request
  logic [15:0] rmux; // read data selected by address
  logic [15:0] clr; // status bits to clear
  logic [15:0] evt_bits; // status bits to set

  // ****************************************************************
  // read mux
  // ****************************************************************
  // unmapped and write-only locations read as zero
  // captured at the request edge, so the master must hold the address
  always_comb begin
    if (address == ADR_CTRL1) begin
      rmux = s_q.ctrl1;
    end else if (address == ADR_IRQEN) begin
      rmux = s_q.irqen;
    end else if (address == ADR_STAT) begin
      rmux = s_q.stat & ST_MASK;
    end else if (address == ADR_FCTL2) begin
      // bypass status is live state, not stored writable data
      rmux = s_q.fctl2 & FCTL2_WMASK;
      rmux[F2_BYPST] = s_q.byp_st;
    end else begin
      rmux = 16'h0000;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    done = 1'b0;
    // bus handshake: one wait cycle, then waitrequest low for one
    // fixed latency costs a cycle per access but keeps masters simple
    case (s_q.st)
      S_IDLE: begin
        if (read || write) begin
          s_d.st = S_ACK;
          s_d.wreq = 1'b0;
          // capture now so data stands at the completing edge
          s_d.rdata = read ? rmux : 16'h0000;
        end
      end
      S_ACK: begin
        s_d.st = S_IDLE;
        s_d.wreq = 1'b1;
        done = 1'b1;
      end
      default: begin
        s_d.st = S_IDLE;
        s_d.wreq = 1'b1;
      end
    endcase
    wr_acc = done && write;
    rd_acc = done && read;
    sw_rst = wr_acc && address == ADR_SWRST && writedata[B_SWRST];

    // register writes; reserved fields are stored as written
    if (wr_acc && address == ADR_CTRL1) begin
      s_d.ctrl1 = writedata[15:0];
    end
    if (wr_acc && address == ADR_IRQEN) begin
      s_d.irqen = writedata[15:0];
    end
    if (wr_acc && address == ADR_FCTL2) begin
      s_d.fctl2 = writedata[15:0] & FCTL2_WMASK;
    end

    // clear only bits the reader actually saw, so an event that
    // lands between capture and completion survives
    clr = 16'h0000;
    if (rd_acc && address == ADR_STAT) begin
      clr = s_q.rdata;
    end else if (wr_acc && address == ADR_STAT) begin
      clr = writedata[15:0]; // write one to clear
    end
    s_d.stat = s_q.stat & ~clr;

    // soft reset: status clears, update-type settings are applied,
    // retained fields (enables, tx disable) are untouched
    // an event in the same cycle is applied below and survives
    if (sw_rst) begin
      s_d.stat = 16'h0000;
      s_d.byp_st = 1'b0;
      s_d.cfg.byp_en = s_q.fctl2[F2_BYPEN];
      s_d.cfg.pass_odd = s_q.ctrl1[C1_PASS];
      s_d.cfg.rxclk_on = s_q.ctrl1[C1_RXPU];
    end

    // events set after clears so a same-cycle event wins
    evt_bits = 16'h0000;
    evt_bits[ST_FIFO] = evt_i.fifo_err;
    evt_bits[ST_INS] = evt_i.idle_ins;
    evt_bits[ST_DEL] = evt_i.idle_del;
    s_d.stat = s_d.stat | evt_bits;

    // link-up cause; a bypass report wins a same-cycle tie
    if (evt_i.up_bypass) begin
      s_d.byp_st = 1'b1;
    end else if (evt_i.up_an) begin
      s_d.byp_st = 1'b0;
    end

    // outputs computed from next state so pins track registers
    s_d.cfg.tx_dis = s_d.fctl2[F2_TXDIS];
    s_d.an_done = evt_i.an_done && !s_d.byp_st;
    s_d.irq = (|(s_d.stat & s_d.irqen & ST_MASK))
      || s_d.fctl2[F2_FORCE];
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // synchronous reset only; every other change goes through s_d
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= MCR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  // one cycle of latency on every pin, traded for glitch-free outputs
  assign readdata = {16'h0000, s_q.rdata};
  assign waitrequest = s_q.wreq;
  assign cfg_o = s_q.cfg;
  assign an_done_o = s_q.an_done;
  assign irq_o = s_q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // completing access of either direction
  sequence acc_done;
    (read || write) && !waitrequest;
  endsequence

  // write of given address completing
  sequence wr_to(logic [7:0] a);
    write && !waitrequest && address == a;
  endsequence

  // soft reset write completing this edge
  sequence soft_rst;
    sw_rst;
  endsequence

  // status read completing this edge; the clear follows at once
  sequence stat_rd_done;
    read && !waitrequest && address == ADR_STAT;
  endsequence

  // a request waits exactly one cycle then completes
  a_bus_one_wait: assert property (
    $rose(read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  a_byp_gate_an: assert property (
    s_q.byp_st |-> !an_done_o)
    else $error("negotiation complete shown during bypass");

  a_byp_status: assert property (
    evt_i.up_bypass |=> s_q.byp_st ##0 !an_done_o)
    else $error("bypass link-up not reported");

  a_byp_apply: assert property (
    $changed(cfg_o.byp_en) |-> $past(sw_rst))
    else $error("bypass enable changed without soft reset");

  a_pass_apply: assert property (
    sw_rst |=> cfg_o.pass_odd == $past(s_q.ctrl1[C1_PASS]))
    else $error("preamble option not applied at soft reset");

  a_rxclk_hold: assert property (
    !sw_rst |=> $stable(cfg_o.rxclk_on))
    else $error("rx clock control changed without soft reset");

  a_txdis_write: assert property (
    wr_to(ADR_FCTL2) |=> cfg_o.tx_dis == $past(writedata[F2_TXDIS]))
    else $error("transmitter disable not taken from write");

  a_en_retain: assert property (
    sw_rst |=> $stable(s_q.irqen))
    else $error("interrupt enables lost on soft reset");

  a_fifo_latch: assert property (
    evt_i.fifo_err ##1 !((done && address == ADR_STAT) || sw_rst)
      |=> s_q.stat[ST_FIFO])
    else $error("fifo error not latched");

  a_idle_latch: assert property (
    evt_i.idle_ins |=> s_q.stat[ST_INS])
    else $error("idle insert not latched");

  a_stat_rdclr: assert property (
    read && !waitrequest && address == ADR_STAT && s_q.rdata[ST_DEL]
      && !evt_i.idle_del && !sw_rst |=> !s_q.stat[ST_DEL])
    else $error("status bit not cleared by read");

  a_irq_level: assert property (
    (s_q.stat[ST_FIFO] && s_q.irqen[ST_FIFO]) |-> irq_o)
    else $error("enabled status bit without interrupt");

  // ****************************************************************
  // further checks: bus, register store, bypass, soft reset, latching, interrupt
  // ****************************************************************

  // a completed access is followed by waitrequest high again
  a_ack_one_cycle: assert property (
    acc_done |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // with nothing asked, the slave keeps stalling
  a_wreq_idle: assert property (
    !(read || write) && waitrequest |=> waitrequest)
    else $error("waitrequest dropped without a request");

  // control one keeps reserved bits exactly as software wrote them
  a_ctrl1_store: assert property (
    wr_to(ADR_CTRL1) |=> s_q.ctrl1 == $past(writedata[15:0]))
    else $error("control one write not stored");

  // soft reset copies the stored bypass enable to the datapath
  a_byp_en_apply: assert property (
    soft_rst |=> cfg_o.byp_en == $past(s_q.fctl2[F2_BYPEN]))
    else $error("bypass enable not applied at soft reset");

  // regular negotiation clears the bypass report
  a_byp_an_clear: assert property (
    evt_i.up_an && !evt_i.up_bypass |=> !s_q.byp_st)
    else $error("bypass status kept after regular negotiation");

  // bypass report moves only on a link-up cause or soft reset
  a_byp_hold: assert property (
    !evt_i.up_bypass && !evt_i.up_an && !sw_rst |=> $stable(s_q.byp_st))
    else $error("bypass status moved with no cause");

  // writes never reach the read-only bypass status position
  a_byp_ro: assert property (
    wr_to(ADR_FCTL2) |=> !s_q.fctl2[F2_BYPST])
    else $error("bypass status position took write data");

  // a read of fiber control two shows the live bypass status
  a_byp_rd: assert property (
    $rose(read) && waitrequest && address == ADR_FCTL2
      |=> readdata[F2_BYPST] == $past(s_q.byp_st))
    else $error("bypass status not shown on read");

  // transmitter disable survives soft reset
  a_txdis_retain: assert property (
    soft_rst |=> $stable(cfg_o.tx_dis))
    else $error("transmitter disable lost on soft reset");

  // preamble option moves only at soft reset
  a_pass_hold: assert property (
    !sw_rst |=> $stable(cfg_o.pass_odd))
    else $error("preamble option changed without soft reset");

  // rx clock policy takes the stored bit at soft reset
  a_rxclk_apply: assert property (
    soft_rst |=> cfg_o.rxclk_on == $past(s_q.ctrl1[C1_RXPU]))
    else $error("rx clock control not applied at soft reset");

  // enables take the written word at the completing edge
  a_en_store: assert property (
    wr_to(ADR_IRQEN) |=> s_q.irqen == $past(writedata[15:0]))
    else $error("interrupt enable write not stored");

  // soft reset empties the latched fifo bit
  a_stat_swclr: assert property (
    soft_rst ##0 !evt_i.fifo_err |=> !s_q.stat[ST_FIFO])
    else $error("fifo status survived soft reset");

  // soft reset empties the idle inserted bit too
  a_ins_swclr: assert property (
    soft_rst ##0 !evt_i.idle_ins |=> !s_q.stat[ST_INS])
    else $error("idle insert status survived soft reset");

  // idle deleted latches on the next edge
  a_del_latch: assert property (
    evt_i.idle_del |=> s_q.stat[ST_DEL])
    else $error("idle delete not latched");

  // a read that showed the fifo bit clears it
  a_fifo_rdclr: assert property (
    stat_rd_done ##0 (s_q.rdata[ST_FIFO] && !evt_i.fifo_err)
      |=> !s_q.stat[ST_FIFO])
    else $error("fifo status not cleared by read");

  // reserved status bits always read as zero
  a_stat_resvd: assert property (
    stat_rd_done |-> (readdata[15:0] & ~ST_MASK) == 16'h0000)
    else $error("reserved status bit read as one");

  // any enabled latched bit holds the interrupt up
  a_irq_any: assert property (
    (|(s_q.stat & s_q.irqen & ST_MASK)) |-> irq_o)
    else $error("interrupt low with an enabled bit set");

  // no enabled bit and no force: interrupt stays low
  a_irq_quiet: assert property (
    !(|(s_q.stat & s_q.irqen & ST_MASK)) && !s_q.fctl2[F2_FORCE]
      |-> !irq_o)
    else $error("interrupt raised with nothing enabled");

endmodule

`default_nettype wire

// *** mcr_pkg.sv ***
// constants and types for the mac-side config and status register bank
package mcr_pkg;

  // ****************************************************************
  // register indices; byte address on the bus is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_SWRST = 8'h00; // soft reset trigger
  localparam logic [7:0] IDX_CTRL1 = 8'h10; // mac_side_control_one
  localparam logic [7:0] IDX_IRQEN = 8'h12; // mac_side_irq_enable
  localparam logic [7:0] IDX_STAT = 8'h13; // mac_side_status
  localparam logic [7:0] IDX_FCTL2 = 8'h1A; // fiber_control_two
  localparam logic [7:0] ADR_SWRST = IDX_SWRST << 2;
  localparam logic [7:0] ADR_CTRL1 = IDX_CTRL1 << 2;
  localparam logic [7:0] ADR_IRQEN = IDX_IRQEN << 2;
  localparam logic [7:0] ADR_STAT = IDX_STAT << 2;
  localparam logic [7:0] ADR_FCTL2 = IDX_FCTL2 << 2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int B_SWRST = 15; // soft reset request, self clearing
  localparam int C1_PASS = 6; // pass odd nibble preambles
  localparam int C1_RXPU = 3; // rgmii rx clock always powered
  localparam int F2_FORCE = 15; // force interrupt
  localparam int F2_BYPEN = 6; // serial an bypass enable
  localparam int F2_BYPST = 5; // serial an bypass status
  localparam int F2_TXDIS = 3; // fiber transmitter disable
  localparam int ST_FIFO = 7; // copper fifo over/underflow
  localparam int ST_INS = 3; // idle inserted
  localparam int ST_DEL = 2; // idle deleted

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [15:0] CTRL1_RST = 16'hC448;
  localparam logic [15:0] IRQEN_RST = 16'h0000;
  localparam logic [15:0] FCTL2_RST = 16'h0042;
  localparam logic [15:0] FCTL2_WMASK = 16'hFFDF; // bit 5 is read only
  localparam logic [15:0] ST_MASK = 16'h008C; // implemented status bits

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    S_IDLE = 2'b01, // waiting for a bus request
    S_ACK = 2'b10 // waitrequest low, access completes
  } mcr_bus_st_t;

  typedef struct packed {
    logic fifo_err; // copper fifo over/underflow pulse
    logic idle_ins; // idle inserted pulse
    logic idle_del; // idle deleted pulse
    logic up_bypass; // serial link up via bypass timer
    logic up_an; // serial link up via regular negotiation
    logic an_done; // raw fiber negotiation complete level
  } mcr_evt_t;

  typedef struct packed {
    logic byp_en; // applied bypass enable
    logic pass_odd; // applied preamble pass option
    logic rxclk_on; // applied rgmii rx clock always on
    logic tx_dis; // fiber transmitter disabled
  } mcr_cfg_t;

  typedef struct packed {
    mcr_bus_st_t st; // bus handshake state
    logic wreq; // waitrequest
    logic [15:0] rdata; // captured read data
    logic [15:0] ctrl1; // mac control one
    logic [15:0] irqen; // interrupt enables
    logic [15:0] fctl2; // fiber control two, bit 5 unused
    logic [15:0] stat; // latched status
    logic byp_st; // bypass status
    mcr_cfg_t cfg; // settings seen by the datapath
    logic an_done; // gated negotiation complete
    logic irq; // interrupt level
  } mcr_state_t;

  localparam mcr_state_t MCR_RST = '{
    st: S_IDLE, wreq: 1'b1, rdata: 16'h0000, ctrl1: CTRL1_RST,
    irqen: IRQEN_RST, fctl2: FCTL2_RST, stat: 16'h0000,
    byp_st: 1'b0, cfg: '{1'b1, 1'b1, 1'b1, 1'b0},
    an_done: 1'b0, irq: 1'b0};

endpackage

// *** mcr_far_model.sv ***
// far-side datapath model that raises events toward the register bank
`timescale 1ns/1ps
`default_nettype none

module mcr_far_model
  import mcr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire mcr_evt_t cmd_i, // event requests from the bench
  output var mcr_evt_t evt_o // events, one cycle after the request
);
  // registered so each event leaves on a clean edge, as real logic does
  always_ff @(posedge clk_sys) begin
    evt_o <= cmd_i;
  end
endmodule

`default_nettype wire

// *** tb_mcr_regs.sv ***
// self-checking testbench for the mac-side register bank
`timescale 1ns/1ps
`default_nettype none

module tb_mcr_regs;
  import mcr_pkg::*;
  logic clk_sys = 1'b0; // 250 mhz clock
  logic srst = 1'b1; // synchronous reset
  logic [7:0] address = 8'h00; // bus address
  logic read = 1'b0; // bus read
  logic write = 1'b0; // bus write
  logic [31:0] writedata = 32'h00000000; // bus write data
  logic [31:0] readdata; // bus read data
  logic waitrequest; // bus stall
  mcr_evt_t cmd = '0; // event requests to the model
  mcr_evt_t evt; // events into the bank
  mcr_cfg_t cfg; // applied settings
  logic an_done; // gated negotiation complete
  logic irq; // interrupt level
  logic an_lvl = 1'b0; // held negotiation-complete level
  logic [15:0] d; // read result
  logic [15:0] bits [3] = '{16'h0080, 16'h0008, 16'h0004}; // status bits
  int n_errors = 0; // mismatches
  int samples_checked = 0; // comparisons

  // ****************************************************************
  // clock, reset and instances
  // ****************************************************************
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  mcr_far_model mcr_far_model_i (.clk_sys(clk_sys), .cmd_i(cmd),
    .evt_o(evt));
  mcr_regs mcr_regs_i (.clk_sys(clk_sys), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .evt_i(evt),
    .cfg_o(cfg), .an_done_o(an_done), .irq_o(irq));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task final_report;
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one avalon access; held until waitrequest is seen low at an edge
  task bus(input logic rd, input logic [7:0] a, input logic [15:0] wd,
      output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= {16'h0000, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (waitrequest !== 1'b0) begin
      n_errors++;
      $display("wrong value at %0t: bus timeout", $time);
      final_report;
    end
    q = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] q;
    bus(1'b0, a, v, q);
  endtask

  task rd(input logic [7:0] a, output logic [15:0] q);
    bus(1'b1, a, 16'h0000, q);
  endtask

  // let the completing edge and the next registered outputs land
  task step;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle event pulse; the negotiation level rides along
  task pulse(input logic [5:0] p);
    @(posedge clk_sys);
    cmd <= mcr_evt_t'(p | {5'b00000, an_lvl});
    @(posedge clk_sys);
    cmd <= mcr_evt_t'({5'b00000, an_lvl});
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    rd(ADR_CTRL1, d); chk(d, 16'hC448);
    rd(ADR_IRQEN, d); chk(d, 16'h0000);
    rd(ADR_FCTL2, d); chk(d, 16'h0042);
    rd(ADR_STAT, d); chk(d, 16'h0000);
    chk({12'h000, cfg}, 16'h000E);
    rd(8'h04, d); chk(d, 16'h0000);
  endtask

  // new options wait for soft reset; transmitter disable does not
  task t_update;
    wr(ADR_CTRL1, 16'hC400);
    wr(ADR_FCTL2, 16'h0002);
    step; chk({12'h000, cfg}, 16'h000E);
    wr(ADR_SWRST, 16'h8000);
    step; chk({12'h000, cfg}, 16'h0000);
    wr(ADR_CTRL1, 16'hC448);
    wr(ADR_FCTL2, 16'h006A);
    step; chk({12'h000, cfg}, 16'h0001);
    wr(ADR_SWRST, 16'h8000);
    step; chk({12'h000, cfg}, 16'h000F);
    rd(ADR_FCTL2, d); chk(d, 16'h004A);
    wr(ADR_FCTL2, 16'h0042);
    step; chk({12'h000, cfg}, 16'h000E);
  endtask

  task t_bypass;
    an_lvl = 1'b1;
    pulse(6'h04);
    rd(ADR_FCTL2, d); chk(d, 16'h0062);
    chk({15'h0000, an_done}, 16'h0000);
    wr(ADR_SWRST, 16'h8000);
    step; chk({15'h0000, an_done}, 16'h0001);
    pulse(6'h04);
    chk({15'h0000, an_done}, 16'h0000);
    pulse(6'h02);
    rd(ADR_FCTL2, d); chk(d, 16'h0042);
    chk({15'h0000, an_done}, 16'h0001);
    an_lvl = 1'b0;
    pulse(6'h00);
  endtask

  // each event masked, then enabled; reading the status clears it
  task t_irq;
    for (int i = 0; i < 3; i++) begin
      wr(ADR_IRQEN, 16'h0000);
      pulse(6'h20 >> i);
      chk({15'h0000, irq}, 16'h0000);
      rd(ADR_STAT, d); chk(d, bits[i]);
      rd(ADR_STAT, d); chk(d, 16'h0000);
      wr(ADR_IRQEN, bits[i]);
      pulse(6'h20 >> i);
      chk({15'h0000, irq}, 16'h0001);
      rd(ADR_STAT, d); chk(d, bits[i]);
      step; chk({15'h0000, irq}, 16'h0000);
    end
    wr(ADR_IRQEN, 16'h008C);
    wr(ADR_SWRST, 16'h8000);
    rd(ADR_IRQEN, d); chk(d, 16'h008C);
    wr(ADR_IRQEN, 16'h0000);
  endtask

  // write one clears chosen bits; soft reset empties; force raises irq
  task t_clear;
    wr(ADR_IRQEN, 16'h008C);
    pulse(6'h38);
    chk({15'h0000, irq}, 16'h0001);
    wr(ADR_STAT, 16'h0080);
    rd(ADR_STAT, d); chk(d, 16'h000C);
    step; chk({15'h0000, irq}, 16'h0000);
    pulse(6'h20);
    wr(ADR_SWRST, 16'h8000);
    rd(ADR_STAT, d); chk(d, 16'h0000);
    wr(ADR_IRQEN, 16'h0000);
    wr(ADR_FCTL2, 16'h8042);
    step; chk({15'h0000, irq}, 16'h0001);
    wr(ADR_FCTL2, 16'h0042);
    step; chk({15'h0000, irq}, 16'h0000);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_update;
    t_bypass;
    t_irq;
    t_clear;
    final_report;
  end
endmodule

`default_nettype wire
